// ### sram_host.sv
// Host controller driving an asynchronous byte-wide static memory over its pins
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_defines.svh"

module sram_host #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W,
	parameter int POWER_WAIT_CYC = `SRAM_POWER_WAIT_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Request side
	input wire sram_host_pkg::req_type req,
	input wire logic req_valid,
	output logic req_ready,
	// Answer side
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// Memory pins
	output logic [ADDR_W-1:0] sram_addr,
	output logic sram_ce_n,
	output logic sram_oe_n,
	output logic sram_we_n,
	output logic [DATA_W-1:0] sram_dq_out,
	output logic sram_dq_oe,
	input wire logic [DATA_W-1:0] sram_dq_in
);

	// ============================================================
	// Elaboration checks
	if (ADDR_W != `SRAM_ADDR_W || DATA_W != `SRAM_DATA_W) begin : g_bad_width
		$error("Widths must match the request type");
	end
	if (POWER_WAIT_CYC < 1 || POWER_WAIT_CYC > 4095) begin : g_bad_wait
		$error("Power wait count out of range");
	end

	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(`SRAM_READ_HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(`SRAM_WRITE_CYC - 1);
	localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(`SRAM_TURN_CYC - 1);
	localparam logic [CNT_W-1:0] POWER_LAST = CNT_W'(POWER_WAIT_CYC - 1);

	// ============================================================
	// Read data synchroniser
	logic [DATA_W-1:0] dq_sync;

	sync3 #(
		.WIDTH(DATA_W)
	) u_dq_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.d(sram_dq_in),
		.q(dq_sync)
	);

	// ============================================================
	// Decoding
	sram_host_pkg::state_type state;
	sram_host_pkg::state_type next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic was_write;

	wire cnt_done = (cnt == '0);
	wire accept = req_valid && req_ready;
	wire start_read = accept && !req.write;
	wire start_write = accept && req.write;
	wire end_read = (state == sram_host_pkg::st_read) && cnt_done;
	wire end_write = (state == sram_host_pkg::st_write) && cnt_done;
	wire end_recover = (state == sram_host_pkg::st_recover) && cnt_done;
	wire end_power = (state == sram_host_pkg::st_powerup) && cnt_done;

	// Output drive stays high on writes so the device never fights our data
	wire sram_host_pkg::ctrl_type ctrl_read = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
	wire sram_host_pkg::ctrl_type ctrl_write = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
	wire sram_host_pkg::ctrl_type ctrl_off = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
	sram_host_pkg::ctrl_type ctrl;
	sram_host_pkg::ctrl_type next_ctrl;

	always_comb begin
		next_state = state;
		next_cnt = cnt_done ? cnt : cnt - 1'b1;
		next_ctrl = ctrl;
		unique case (state)
			sram_host_pkg::st_powerup: begin
				if (cnt_done) begin
					next_state = sram_host_pkg::st_idle;
				end
			end
			sram_host_pkg::st_idle: begin
				if (start_read) begin
					next_state = sram_host_pkg::st_read;
					next_cnt = READ_LAST;
					next_ctrl = ctrl_read;
				end else if (start_write) begin
					next_state = sram_host_pkg::st_write;
					next_cnt = WRITE_LAST;
					next_ctrl = ctrl_write;
				end
			end
			sram_host_pkg::st_read: begin
				if (cnt_done) begin
					next_state = sram_host_pkg::st_recover;
					next_cnt = TURN_LAST;
					next_ctrl = ctrl_off;
				end
			end
			sram_host_pkg::st_write: begin
				// Raising select and strobe together ends the write at once
				if (cnt_done) begin
					next_state = sram_host_pkg::st_recover;
					next_cnt = TURN_LAST;
					next_ctrl = ctrl_off;
				end
			end
			sram_host_pkg::st_recover: begin
				if (cnt_done) begin
					next_state = sram_host_pkg::st_idle;
				end
			end
			default: begin
				next_state = sram_host_pkg::st_idle;
				next_ctrl = ctrl_off;
			end
		endcase
	end

	// ============================================================
	// State and pins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= sram_host_pkg::st_powerup;
			cnt <= POWER_LAST;
			ctrl <= ctrl_off;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ctrl <= next_ctrl;
		end
	end

	assign sram_ce_n = ctrl.ce_n;
	assign sram_oe_n = ctrl.oe_n;
	assign sram_we_n = ctrl.we_n;

	// Address and data change only on accept, with select, never later
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sram_addr <= `SRAM_ADDR_RST;
			sram_dq_out <= `SRAM_DATA_RST;
			was_write <= 1'b0;
		end else if (accept) begin
			sram_addr <= req.addr;
			sram_dq_out <= req.wdata;
			was_write <= req.write;
		end
	end

	// Data stays driven through the recovery cycle so hold is met after the strobe
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sram_dq_oe <= 1'b0;
		end else if (start_write) begin
			sram_dq_oe <= 1'b1;
		end else if (end_recover || end_read) begin
			sram_dq_oe <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			req_ready <= 1'b0;
		end else if (end_power || end_recover) begin
			req_ready <= 1'b1;
		end else if (accept) begin
			req_ready <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= `SRAM_DATA_RST;
		end else begin
			rsp_valid <= end_read;
			if (end_read) begin
				rsp_rdata <= dq_sync;
			end
		end
	end

	// ============================================================
	// Checks
	logic [CNT_W-1:0] since_reset;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			since_reset <= '0;
		end else if (since_reset != '1) begin
			since_reset <= since_reset + 1'b1;
		end
	end

	sequence write_pulse_s;
		!sram_we_n && !sram_ce_n ##1 !sram_we_n && !sram_ce_n ##1 sram_we_n && sram_ce_n;
	endsequence

	// One cycle of driven, unchanged write data
	sequence write_tail_s;
		sram_dq_oe && $stable(sram_dq_out);
	endsequence

	power_wait_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(sram_ce_n) |-> (since_reset >= CNT_W'(POWER_WAIT_CYC)))
		else $error("Access before power wait elapsed");
	read_strobe_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!sram_oe_n |-> sram_we_n)
		else $error("Write strobe low during read");
	bus_clash_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		sram_dq_oe |-> sram_oe_n)
		else $error("Host drives data while device may drive");
	turn_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(sram_oe_n) |-> !sram_dq_oe ##1 !sram_dq_oe)
		else $error("Host drove data right after read");
	addr_stable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!sram_ce_n && $past(!sram_ce_n)) |-> $stable(sram_addr))
		else $error("Address moved while selected");
	write_length_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(sram_we_n) |-> write_pulse_s)
		else $error("Write pulse length wrong");
	write_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(sram_we_n) |-> ##1 write_tail_s ##1 write_tail_s)
		else $error("Write data not held past strobe rise");
	write_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(sram_we_n) |-> $rose(sram_ce_n))
		else $error("Strobe and select did not end together");
	read_answer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(sram_oe_n) |-> ##[1:8] rsp_valid)
		else $error("Read answer missing");

endmodule // sram_host

`default_nettype wire

// ### sram_host_defines.svh
// Constants for the asynchronous byte-wide static memory host controller
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// ============================================================
// Geometry
`define SRAM_ADDR_W 19
`define SRAM_DATA_W 8

// ============================================================
// Timing, slower grade, in their own units
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_POWER_WAIT_US 1
`define SRAM_READ_CYCLE_NS 20
`define SRAM_WRITE_CYCLE_NS 20
`define SRAM_STROBE_PULSE_NS 10
`define SRAM_STROBE_TO_FLOAT_DELAY_NS 8
`define SRAM_WRITE_DATA_SETUP_TIME_NS 8
`define SRAM_OE_TO_FLOAT_NS 8

// Cycle counts, least times rounded up
`define SRAM_CEIL_CYC(ns) (((ns) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
`define SRAM_POWER_WAIT_CYC `SRAM_CEIL_CYC(`SRAM_POWER_WAIT_US * 1000)
`define SRAM_READ_CYC `SRAM_CEIL_CYC(`SRAM_READ_CYCLE_NS)
`define SRAM_SYNC_LAT_CYC 4
`define SRAM_READ_HOLD_CYC (`SRAM_READ_CYC + `SRAM_SYNC_LAT_CYC + 1)
`define SRAM_WR_MIN_NS (`SRAM_STROBE_TO_FLOAT_DELAY_NS + `SRAM_WRITE_DATA_SETUP_TIME_NS)
`define SRAM_WR_A_CYC `SRAM_CEIL_CYC(`SRAM_WR_MIN_NS)
`define SRAM_WR_B_CYC `SRAM_CEIL_CYC(`SRAM_WRITE_CYCLE_NS)
`define SRAM_WRITE_CYC ((`SRAM_WR_A_CYC > `SRAM_WR_B_CYC) ? `SRAM_WR_A_CYC : `SRAM_WR_B_CYC)
`define SRAM_TURN_CYC `SRAM_CEIL_CYC(`SRAM_OE_TO_FLOAT_NS)

// ============================================================
// Reset values of the pins
`define SRAM_CTRL_IDLE 1'b1
`define SRAM_ADDR_RST 19'h00000
`define SRAM_DATA_RST 8'h00

`endif

// ### sram_host_pkg.sv
// Types shared by the static memory host controller
`default_nettype none
`include "sram_host_defines.svh"

package sram_host_pkg;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_read = 3'b001,
		st_recover = 3'b011,
		st_write = 3'b010,
		st_powerup = 3'b110
	} state_type;

	typedef struct packed {
		logic write;
		logic [`SRAM_ADDR_W-1:0] addr;
		logic [`SRAM_DATA_W-1:0] wdata;
	} req_type;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} ctrl_type;

endpackage

`default_nettype wire

// ### sync3.sv
// Three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module sync3 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	if (WIDTH < 1) begin : g_bad_width
		$error("Synchroniser width must be at least one");
	end

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	wire agree = (s2 == s3);

	// Stage one feeds stage two only, to keep metastability contained
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (agree) begin
				q <= s3;
			end
		end
	end

endmodule // sync3

`default_nettype wire

// ### sram_dev_model.sv
// Behavioural model of the byte-wide static memory device
`timescale 1ns/100ps
`default_nettype none

module sram_dev_model #(
	parameter int ACC_NS = 20
) (
	// Memory pins
	input wire logic [18:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dq_bus,
	// Device side of the data lines
	output logic [7:0] dq_drv,
	output logic dq_drv_en,
	output logic standby
);
	// ============================================================
	// Storage and decode
	// Full array, so reads of unwritten bytes give unknowns rather than lookup misses
	logic [7:0] mem [0:(1<<19)-1];
	logic wr_on;
	logic rd_on;
	logic rd_late;
	assign wr_on = !ce_n && !we_n;
	assign rd_on = !ce_n && !oe_n && we_n;
	assign #(ACC_NS) rd_late = rd_on;
	assign #(ACC_NS) standby = ce_n;
	// Output enable alone never drives, so a joint rise stays floating
	assign dq_drv_en = rd_on;
	// Until access time runs out the byte shown is wrong on purpose
	assign dq_drv = rd_late ? mem[addr] : ~mem[addr];
	// Byte lands when whichever of select or strobe rises first
	always @(negedge wr_on) begin
		if (!$isunknown(addr)) mem[addr] = dq_bus;
	end
endmodule // sram_dev_model

`default_nettype wire

// ### async_sram_byte_port_bench.sv
// Self-checking bench of the static memory host controller
`timescale 1ns/100ps
`default_nettype none

module async_sram_byte_port_bench;
	logic clk_sys;
	logic nrst;
	sram_host_pkg::req_type req;
	logic req_valid, req_ready, rsp_valid, sram_ce_n, sram_oe_n, sram_we_n, sram_dq_oe;
	logic dq_drv_en, standby, prev_ce_n;
	logic [7:0] rsp_rdata, sram_dq_out, dq_drv, bus;
	logic [18:0] sram_addr, prev_addr;
	logic [31:0] rnd;
	logic [7:0] shadow [logic [18:0]];
	int mismatches, n_compared, cyc;
	localparam int LIMIT = 5000;

	sram_host sram_host_i (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.sram_addr(sram_addr), .sram_ce_n(sram_ce_n), .sram_oe_n(sram_oe_n),
		.sram_we_n(sram_we_n), .sram_dq_out(sram_dq_out), .sram_dq_oe(sram_dq_oe),
		.sram_dq_in(bus));
	sram_dev_model sram_dev_model_i (.addr(sram_addr), .ce_n(sram_ce_n), .oe_n(sram_oe_n),
		.we_n(sram_we_n), .dq_bus(bus), .dq_drv(dq_drv), .dq_drv_en(dq_drv_en),
		.standby(standby));
	// Undriven lines wander every cycle so a stale byte is never read back
	assign bus = sram_dq_oe ? sram_dq_out : dq_drv_en ? dq_drv : cyc[7:0] ^ 8'ha5;

	// ============================================================
	// Checking and reporting
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ============================================================
	// Pin monitors and hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		prev_ce_n <= sram_ce_n;
		prev_addr <= sram_addr;
		if (nrst === 1'b1) begin
			chk32("bus clash", 32'h0, {31'h0, sram_dq_oe & dq_drv_en});
			chk32("strobe in read", 32'h0, {31'h0, !sram_oe_n & !sram_we_n});
			if (sram_ce_n === 1'b0 && prev_ce_n === 1'b0) begin
				chk32("addr held", {13'h0, prev_addr}, {13'h0, sram_addr});
			end
		end
		if (cyc == LIMIT) begin
			mismatches++;
			final_report();
		end
	end

	// ============================================================
	// Request driver
	task automatic do_req(input logic w, input logic [18:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= '{write: w, addr: a, wdata: d};
		req_valid <= 1'b1;
		@(posedge clk_sys);
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk_sys);
		end
		req_valid <= 1'b0;
	endtask
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		do_req(1'b1, a, d);
		shadow[a] = d;
	endtask
	task automatic rd(input logic [18:0] a);
		int n;
		do_req(1'b0, a, 8'h00);
		n = 0;
		do begin
			n++;
			@(posedge clk_sys);
		end while (rsp_valid !== 1'b1 && n < 30);
		chk32("read latency", 32'd8, n);
		chk8("read data", shadow[a], rsp_rdata);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		int k;
		logic [18:0] a;
		nrst = 1'b0;
		req_valid = 1'b0;
		req = '0;
		rnd = 32'd96184;
		cyc = 0;
		mismatches = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		k = 0;
		@(posedge clk_sys);
		while (req_ready !== 1'b1 && k < 500) begin
			k++;
			@(posedge clk_sys);
		end
		chk32("power wait", 32'h1, {31'h0, k >= 100 && k < 110});
		chk8("standby", 8'h01, {7'h0, standby});
		$display("test power_up done");
		// Extreme addresses and data patterns, then read back
		wr(19'h00000, 8'hff);
		wr(19'h7ffff, 8'h00);
		wr(19'h40000, 8'h5a);
		rd(19'h7ffff);
		rd(19'h00000);
		rd(19'h40000);
		$display("test corners done");
		// Overwrite then read straight after the write
		wr(19'h00001, 8'h3c);
		wr(19'h00001, 8'hc3);
		rd(19'h00001);
		$display("test overwrite done");
		for (int i = 0; i < 30; i++) begin
			rnd = lfsr(rnd);
			wr(rnd[18:0], rnd[26:19]);
			if (rnd[31]) rd(rnd[18:0]);
		end
		foreach (shadow[x]) begin
			a = x;
			rd(a);
		end
		$display("test random done");
		final_report();
	end
endmodule // async_sram_byte_port_bench

`default_nettype wire
